/* pkg/meter_cfg.svh */
/*
 Register offsets, field positions, reset values and timing counts
 of the metering block.
 Assumes inclusion by bare name from the modules.
*/
`ifndef METER_CFG_SVH
`define METER_CFG_SVH

// ==========================================================
// register offsets
`define OFS_ALERT_MASK 8'h03
`define OFS_ALERT_LOG 8'h05
`define OFS_PIN_CFG 8'h07
`define OFS_THR_BASE 8'h08
`define OFS_CLK_DIV 8'h10
`define OFS_SETUP 8'h11
`define OFS_ALERT_CTL 8'h1C
`define OFS_CONV_CTL 8'h1D
`define OFS_PIN_STAT 8'h1F
`define OFS_ENERGY 8'h20
`define OFS_COUNT 8'h26
`define OFS_RESULT 8'h30
`define NUM_ENERGY 8'h06
`define NUM_COUNT 8'h04
`define NUM_RESULT 8'h18

// ==========================================================
// field positions
`define SETUP_RES16 0
`define SETUP_AUX3 1
`define SETUP_VOUT 2
`define CLKDIV_CHARGE 7
`define PIN_STRESS_EN 1
`define PIN_DONE_ALERT 2
`define PIN_ONE_LO 4
`define PIN_ONE_HI 5
`define PIN_TWO_HIGH 6
`define PIN_THREE_LOW 7
`define ACTL_METER_EN 0
`define ACTL_COUNT_EN 1
`define ACTL_PULL 6
`define ACTL_RESPOND 7
`define CONV_METER_RST 6

// ==========================================================
// reset values and pin one modes
`define REG_RST 8'h00
`define MIN_RST 16'hFFFF
`define MAX_RST 16'h0000
`define ONE_PGOOD 2'h0
`define ONE_PBAD 2'h1
`define ONE_LOW 2'h2
`define ONE_INPUT 2'h3

// ==========================================================
// timing: printed times, conversion clock, derived tick counts
`define T_CONV12_US 32'h0000FFFF
`define T_CONV16_US 32'h00100018
`define CONV_CLK_KHZ 32'h000000FA
`define SYS_CLK_KHZ 32'h000186A0
`define CONV12_TICKS ((`T_CONV12_US * `CONV_CLK_KHZ + 32'h1F4) / 32'h3E8)
`define CONV16_TICKS ((`T_CONV16_US * `CONV_CLK_KHZ + 32'h1F4) / 32'h3E8)
`define INT_OSC_DIV (`SYS_CLK_KHZ / `CONV_CLK_KHZ)
`define CLOCK_INPUT_PIN_IDLE_CYC 32'h00000040
`define THR_SCALE 17'h00101

`endif

/* pkg/meter_pkg.sv */
/*
 Types shared by the metering block.
 Assumes meter_cfg.svh sits on the include path.
*/
package meter_pkg;
    typedef logic [15:0] word_type;
    typedef enum {ST_IDLE, ST_CAPTURE, ST_UPDATE} conv_state_type;
endpackage

/* logic/conv_clock_div.sv */
/*
 Conversion clock source: internal divider of CLK, or the divided
 clock input pin once it toggles.
 Assumes pin_lvl is already synchronised to clk.
*/
`timescale 1ns/10ps
`include "meter_cfg.svh"
module conv_clock_div
    import meter_pkg::*;
#(
    parameter int INT_DIV = `INT_OSC_DIV,
    parameter int IDLE_CYC = `CLOCK_INPUT_PIN_IDLE_CYC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // synchronised pin level and divider code
    input wire logic pin_lvl,
    input wire logic [4:0] div_code,
    // one-cycle conversion clock enable
    output logic conv_en,
    output logic ext_sel
);
    localparam int IW = $clog2(IDLE_CYC);
    localparam int OW = $clog2(INT_DIV);
    logic lvl_d_r;
    logic rise;
    logic [IW-1:0] idle_r;
    logic [OW-1:0] osc_r;
    logic [5:0] edge_r;
    logic edge_last;
    logic osc_last;

    // ======================================================
    // edge detect on the already synchronised level
    always_ff @(posedge clk)
    begin
        if (rst)
            lvl_d_r <= 1'b0;
        else
            lvl_d_r <= pin_lvl;
    end
    assign rise = pin_lvl & ~lvl_d_r;

    // a pin with no edges for a while counts as grounded
    always_ff @(posedge clk)
    begin
        if (rst)
            idle_r <= IW'(IDLE_CYC - 1);
        else if (rise)
            idle_r <= '0;
        else if (idle_r != IW'(IDLE_CYC - 1))
            idle_r <= idle_r + 1'b1;
    end
    assign ext_sel = (idle_r != IW'(IDLE_CYC - 1));

    // internal oscillator stand-in
    always_ff @(posedge clk)
    begin
        if (rst || osc_last)
            osc_r <= '0;
        else
            osc_r <= osc_r + 1'b1;
    end
    assign osc_last = (osc_r == OW'(INT_DIV - 1));

    // external edges divided by twice the code, zero passes through
    assign edge_last = (div_code == 5'h00) ||
                       (edge_r == {div_code, 1'b0} - 6'h01);
    always_ff @(posedge clk)
    begin
        if (rst || !ext_sel)
            edge_r <= 6'h00;
        else if (rise)
            edge_r <= edge_last ? 6'h00 : edge_r + 6'h01;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            conv_en <= 1'b0;
        else
            conv_en <= ext_sel ? (rise && edge_last) : osc_last;
    end
endmodule

/* logic/power_monitor_metering.sv */
/*
 Metering section: result capture, power, min/max, alarms, energy
 meter, conversion counter, pin control and register file.
 Assumes converter codes arrive on CLK, the serial interface
 drives the register port, and pins resolve open drain outside.
*/
`timescale 1ns/10ps
`include "meter_cfg.svh"
module power_monitor_metering
    import meter_pkg::*;
#(
    parameter int CONV12_TICKS = `CONV12_TICKS,
    parameter int CONV16_TICKS = `CONV16_TICKS,
    parameter int ACC_W = 48,
    parameter int CNT_W = 32
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // register port from the serial interface
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // converter codes, right justified in 12 bit mode
    input wire logic [15:0] SENSE_CODE,
    input wire logic [15:0] VIN_CODE,
    input wire logic [15:0] VOUT_CODE,
    input wire logic [15:0] AUX_TWO_CODE,
    input wire logic [15:0] AUX_THREE_CODE,
    // hot swap core status
    input wire logic POWER_GOOD,
    input wire logic FET_STRESS,
    // conversion clock pins
    input wire logic CLOCK_INPUT_PIN,
    output logic CRYSTAL_DRIVE_PIN,
    // open drain pins
    input wire logic AUX_PIN_ONE_I,
    output logic AUX_PIN_ONE_O,
    output logic AUX_PIN_ONE_OE,
    input wire logic AUX_PIN_TWO_I,
    output logic AUX_PIN_TWO_O,
    output logic AUX_PIN_TWO_OE,
    input wire logic AUX_PIN_THREE_I,
    output logic AUX_PIN_THREE_O,
    output logic AUX_PIN_THREE_OE,
    input wire logic ALERT_N_I,
    output logic ALERT_N_O,
    output logic ALERT_N_OE,
    // alert response participation and conversion strobe
    output logic ALERT_RESPONSE_EN,
    output logic CONV_DONE
);
    localparam int PW = $clog2(CONV16_TICKS + 1);
    logic [7:0] mask_r, log_r, pincfg_r, clkdiv_r;
    logic [7:0] setup_r, actl_r, convctl_r, rd_val;
    logic [7:0] thr_r [8];
    word_type val_r [4];
    word_type min_r [4];
    word_type max_r [4];
    word_type neww [4];
    logic [ACC_W-1:0] acc_r, add;
    logic [CNT_W-1:0] cnt_r;
    logic [31:0] prod;
    logic [4:0] s1_r, s2_r;
    logic [PW-1:0] per_r, per_last;
    logic [7:0] trip, trip_d_r;
    logic acc_carry, cnt_full, meter_ovf_r, count_ovf_r;
    logic conv_en, ext_sel, conv_end, mrst, wr_meter;
    conv_state_type state_r;

    // ======================================================
    // returns a 12 bit code left justified when not in 16 bit mode
    function automatic word_type justify(input word_type c,
                                         input logic r16);
        justify = r16 ? c : {c[11:0], 4'h0};
    endfunction

    // threshold byte scaled to the 16 bit result word
    function automatic logic [16:0] scale(input logic [8:0] t);
        scale = 17'(t * `THR_SCALE);
    endfunction

    // ======================================================
    // pin synchronisers: alert, pin one, two, three, clock input
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            s1_r <= 5'h00;
            s2_r <= 5'h00;
        end
        else
        begin
            s1_r <= {CLOCK_INPUT_PIN, AUX_PIN_THREE_I, AUX_PIN_TWO_I,
                     AUX_PIN_ONE_I, ALERT_N_I};
            s2_r <= s1_r;
        end
    end

    conv_clock_div u_clk (
        .clk(CLK),
        .rst(RST),
        .pin_lvl(s2_r[4]),
        .div_code(clkdiv_r[4:0]),
        .conv_en(conv_en),
        .ext_sel(ext_sel)
    );

    // crystal drive inverts the sensed input, idle when grounded
    always_ff @(posedge CLK)
    begin
        if (RST)
            CRYSTAL_DRIVE_PIN <= 1'b0;
        else
            CRYSTAL_DRIVE_PIN <= ext_sel & ~s2_r[4];
    end

    // ======================================================
    // conversion period in conversion clock ticks
    assign per_last = setup_r[`SETUP_RES16] ?
                      PW'(CONV16_TICKS - 1) : PW'(CONV12_TICKS - 1);
    assign conv_end = conv_en && (per_r >= per_last);
    always_ff @(posedge CLK)
    begin
        if (RST || conv_end)
            per_r <= '0;
        else if (conv_en)
            per_r <= per_r + 1'b1;
    end

    // capture then update, so power sees the fresh pair
    always_ff @(posedge CLK)
    begin
        if (RST)
            state_r <= ST_IDLE;
        else
            case (state_r)
                ST_IDLE: if (conv_end) state_r <= ST_CAPTURE;
                ST_CAPTURE: state_r <= ST_UPDATE;
                ST_UPDATE: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            CONV_DONE <= 1'b0;
        else
            CONV_DONE <= (state_r == ST_UPDATE);
    end

    // ======================================================
    // results: 0 power, 1 current, 2 supply/output, 3 aux
    assign prod = val_r[1] * val_r[2];
    always_comb
    begin
        neww[0] = prod[31:16];
        neww[1] = val_r[1];
        neww[2] = val_r[2];
        neww[3] = val_r[3];
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            for (int i = 0; i < 4; i++)
                val_r[i] <= 16'h0000;
        else if (state_r == ST_CAPTURE)
        begin
            val_r[1] <= justify(SENSE_CODE,
                                setup_r[`SETUP_RES16]);
            val_r[2] <= justify(setup_r[`SETUP_VOUT] ? VOUT_CODE :
                                VIN_CODE, setup_r[`SETUP_RES16]);
            val_r[3] <= justify(setup_r[`SETUP_AUX3] ? AUX_THREE_CODE :
                                AUX_TWO_CODE, setup_r[`SETUP_RES16]);
        end
        else if (state_r == ST_UPDATE)
            val_r[0] <= neww[0];
    end

    // min/max on every quantity after each conversion
    always_ff @(posedge CLK)
    begin
        if (RST)
            for (int i = 0; i < 4; i++)
            begin
                min_r[i] <= `MIN_RST;
                max_r[i] <= `MAX_RST;
            end
        else if (state_r == ST_UPDATE)
            for (int i = 0; i < 4; i++)
            begin
                if (neww[i] < min_r[i]) min_r[i] <= neww[i];
                if (neww[i] > max_r[i]) max_r[i] <= neww[i];
            end
    end

    // alarm k: quantity k/2, even k rising, odd k falling
    always_comb
    begin
        for (int k = 0; k < 8; k++)
            if (k % 2 == 0)
                trip[7-k] = {1'b0, neww[k/2]} >= scale({1'b0, thr_r[k]});
            else
                trip[7-k] = {1'b0, neww[k/2]} <
                            scale({1'b0, thr_r[k]} + 9'h001);
    end

    // ======================================================
    // energy meter and conversion counter
    assign mrst = convctl_r[`CONV_METER_RST];
    assign add = clkdiv_r[`CLKDIV_CHARGE] ?
                 ACC_W'(val_r[1]) : ACC_W'(prod[31:8]);
    assign acc_carry = (state_r == ST_UPDATE) &&
                       ({1'b0, acc_r} + {1'b0, add} >> ACC_W) != '0;
    assign cnt_full = (state_r == ST_UPDATE) &&
                      (cnt_r + 1'b1 == '1);
    assign wr_meter = REG_WR && REG_ADDR >= `OFS_ENERGY &&
                      REG_ADDR < `OFS_COUNT + `NUM_COUNT;

    always_ff @(posedge CLK)
    begin
        if (RST || mrst)
        begin
            acc_r <= '0;
            cnt_r <= '0;
        end
        else if (wr_meter)
        begin
            for (int i = 0; i < 6; i++)
                if (REG_ADDR == `OFS_ENERGY + 8'(i))
                    acc_r[8*(5-i) +: 8] <= REG_WDATA;
            for (int i = 0; i < 4; i++)
                if (REG_ADDR == `OFS_COUNT + 8'(i))
                    cnt_r[8*(3-i) +: 8] <= REG_WDATA;
        end
        else if (state_r == ST_UPDATE)
        begin
            acc_r <= acc_r + add;
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // overflow flags hold until the meter is reset
    always_ff @(posedge CLK)
    begin
        if (RST || mrst)
        begin
            meter_ovf_r <= 1'b0;
            count_ovf_r <= 1'b0;
        end
        else
        begin
            if (acc_carry && !wr_meter) meter_ovf_r <= 1'b1;
            if (cnt_full && !wr_meter) count_ovf_r <= 1'b1;
        end
    end

    // ======================================================
    // register writes; hardware sets of log and respond bits win over software clears
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            mask_r <= `REG_RST;
            pincfg_r <= `REG_RST;
            clkdiv_r <= `REG_RST;
            setup_r <= `REG_RST;
            convctl_r <= `REG_RST;
            for (int k = 0; k < 8; k++)
                thr_r[k] <= `REG_RST;
        end
        else if (REG_WR)
            case (REG_ADDR)
                `OFS_ALERT_MASK: mask_r <= REG_WDATA;
                `OFS_PIN_CFG: pincfg_r <= REG_WDATA;
                `OFS_CLK_DIV: clkdiv_r <= REG_WDATA;
                `OFS_SETUP: setup_r <= REG_WDATA;
                `OFS_CONV_CTL: convctl_r <= REG_WDATA;
                default:
                    for (int k = 0; k < 8; k++)
                        if (REG_ADDR == `OFS_THR_BASE + 8'(k))
                            thr_r[k] <= REG_WDATA;
            endcase
    end

    // alarm log, trips remembered so held faults alert once
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            log_r <= `REG_RST;
            trip_d_r <= 8'h00;
        end
        else
        begin
            if (REG_WR && REG_ADDR == `OFS_ALERT_LOG)
                log_r <= REG_WDATA |
                         ((state_r == ST_UPDATE) ? trip : 8'h00);
            else if (state_r == ST_UPDATE)
                log_r <= log_r | trip;
            if (state_r == ST_UPDATE)
                trip_d_r <= trip;
        end
    end

    // alert control: enabled events set the respond bit
    always_ff @(posedge CLK)
    begin
        if (RST)
            actl_r <= `REG_RST;
        else
        begin
            if (REG_WR && REG_ADDR == `OFS_ALERT_CTL)
                actl_r <= REG_WDATA;
            if ((state_r == ST_UPDATE &&
                 ((trip & ~trip_d_r & mask_r) != 8'h00 ||
                  pincfg_r[`PIN_DONE_ALERT])) ||
                (acc_carry && actl_r[`ACTL_METER_EN]) ||
                (cnt_full && actl_r[`ACTL_COUNT_EN]))
                actl_r[`ACTL_RESPOND] <= 1'b1;
        end
    end

    // ======================================================
    // open drain pins: output value low, enable means pulling
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            AUX_PIN_ONE_OE <= 1'b0;
            AUX_PIN_TWO_OE <= 1'b0;
            AUX_PIN_THREE_OE <= 1'b0;
            ALERT_N_OE <= 1'b0;
        end
        else
        begin
            case (pincfg_r[`PIN_ONE_HI:`PIN_ONE_LO])
                `ONE_PGOOD: AUX_PIN_ONE_OE <= ~POWER_GOOD;
                `ONE_PBAD: AUX_PIN_ONE_OE <= POWER_GOOD;
                `ONE_LOW: AUX_PIN_ONE_OE <= 1'b1;
                default: AUX_PIN_ONE_OE <= 1'b0;
            endcase
            AUX_PIN_TWO_OE <= pincfg_r[`PIN_STRESS_EN] ? FET_STRESS :
                              ~pincfg_r[`PIN_TWO_HIGH];
            AUX_PIN_THREE_OE <= pincfg_r[`PIN_THREE_LOW];
            ALERT_N_OE <= actl_r[`ACTL_PULL] |
                          actl_r[`ACTL_RESPOND];
        end
    end
    assign AUX_PIN_ONE_O = 1'b0;
    assign AUX_PIN_TWO_O = 1'b0;
    assign AUX_PIN_THREE_O = 1'b0;
    assign ALERT_N_O = 1'b0;
    assign ALERT_RESPONSE_EN = actl_r[`ACTL_RESPOND];

    // ======================================================
    // read mux, registered on the read strobe
    always_comb
    begin
        rd_val = 8'h00;
        case (REG_ADDR)
            `OFS_ALERT_MASK: rd_val = mask_r;
            `OFS_ALERT_LOG: rd_val = log_r;
            `OFS_PIN_CFG: rd_val = pincfg_r;
            `OFS_CLK_DIV: rd_val = clkdiv_r;
            `OFS_SETUP: rd_val = setup_r;
            `OFS_ALERT_CTL: rd_val = actl_r;
            `OFS_CONV_CTL: rd_val = convctl_r;
            `OFS_PIN_STAT: rd_val = {s2_r[3:0], 2'h0, meter_ovf_r,
                                     count_ovf_r};
            default:
            begin
                for (int k = 0; k < 8; k++)
                    if (REG_ADDR == `OFS_THR_BASE + 8'(k))
                        rd_val = thr_r[k];
                for (int i = 0; i < 6; i++)
                    if (REG_ADDR == `OFS_ENERGY + 8'(i))
                        rd_val = acc_r[8*(5-i) +: 8];
                for (int i = 0; i < 4; i++)
                    if (REG_ADDR == `OFS_COUNT + 8'(i))
                        rd_val = cnt_r[8*(3-i) +: 8];
                // per quantity: value, min, max, each MSB first
                for (int q = 0; q < 4; q++)
                    for (int b = 0; b < 2; b++)
                    begin
                        if (REG_ADDR == `OFS_RESULT + 8'(q*6+b))
                            rd_val = val_r[q][8*(1-b) +: 8];
                        if (REG_ADDR == `OFS_RESULT + 8'(q*6+2+b))
                            rd_val = min_r[q][8*(1-b) +: 8];
                        if (REG_ADDR == `OFS_RESULT + 8'(q*6+4+b))
                            rd_val = max_r[q][8*(1-b) +: 8];
                    end
            end
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            REG_RDATA <= 8'h00;
        else if (REG_RD)
            REG_RDATA <= rd_val;
    end

    // ======================================================
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence conv_steps;
        state_r == ST_CAPTURE ##1 state_r == ST_UPDATE ##1 CONV_DONE;
    endsequence
    conv_order_a: assert property (conv_end && state_r == ST_IDLE |=> conv_steps)
        else $error("conversion sequence broken");
    justify_low_a: assert property (state_r == ST_CAPTURE && !setup_r[`SETUP_RES16] |=> val_r[1][3:0] == 4'h0)
        else $error("12 bit result not left justified");
    power_word_a: assert property (state_r == ST_UPDATE |=> val_r[0] == $past(prod[31:16]))
        else $error("power word wrong");
    min_track_a: assert property (state_r == ST_UPDATE |=> min_r[1] <= val_r[1] && max_r[2] >= val_r[2])
        else $error("min max not tracked");
    log_set_a: assert property (state_r == ST_UPDATE && trip[7] |=> log_r[7])
        else $error("alarm log not set");
    acc_step_a: assert property (state_r == ST_UPDATE && !mrst && !wr_meter |=> acc_r == $past(acc_r) + $past(add) && cnt_r == $past(cnt_r) + 1'b1)
        else $error("meter step wrong");
    meter_clear_a: assert property (mrst |=> !meter_ovf_r && !count_ovf_r && acc_r == '0)
        else $error("meter reset did not clear");
    pin_three_a: assert property (pincfg_r[`PIN_THREE_LOW] |=> AUX_PIN_THREE_OE)
        else $error("pin three not pulling");
    alert_pull_a: assert property (actl_r[`ACTL_PULL] |=> ALERT_N_OE)
        else $error("alert pin not pulling");
endmodule

/* tb/tb.sv */
/*
 Self-checking bench of the metering block: register port, pin
 drivers, pin status, two conversions' results, meter reset and
 conversion spacing in both resolutions.
 Assumes the design, its package and its header are compiled first.
*/
`timescale 1ns/10ps
module tb;
    // ======================================================
    // clock, reset and stimulus
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic oe1, oe2, oe3, alert_oe, resp_en, done;
    logic [15:0] n;
    logic [15:0] sense = 16'h0800;
    logic [15:0] vin = 16'h0400;
    logic [15:0] vout = 16'h0200;
    logic [15:0] aux2 = 16'h0FFF;
    logic [15:0] aux3 = 16'h0001;
    logic pg = 1'b1;
    logic stress = 1'b0;
    logic clock_input_pin = 1'b0;
    logic ext_on = 1'b0;
    logic [1:0] ext_cnt = 2'h0;
    logic [3:0] pins = 4'hB;
    logic xdrv, o1, o2, o3, alo;
    int error_cnt = 0;
    int n_tests = 0;

    // clock at 100 MHz
    always #5 CLK = ~CLK;

    // external clock pin at 12.5 MHz, inside the accepted range
    always @(posedge CLK)
    begin
        if (ext_on)
        begin
            ext_cnt <= ext_cnt + 2'h1;
            if (ext_cnt == 2'h3)
                clock_input_pin <= ~clock_input_pin;
        end
    end

    // short periods keep the run small: 8 and 16 ticks of 400 cycles
    power_monitor_metering #(.CONV12_TICKS(8), .CONV16_TICKS(16))
    u_power_monitor_metering (
        .CLK(CLK), .RST(RST),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdata),
        .SENSE_CODE(sense), .VIN_CODE(vin), .VOUT_CODE(vout),
        .AUX_TWO_CODE(aux2), .AUX_THREE_CODE(aux3),
        .POWER_GOOD(pg), .FET_STRESS(stress),
        .CLOCK_INPUT_PIN(clock_input_pin), .CRYSTAL_DRIVE_PIN(xdrv),
        .AUX_PIN_ONE_I(pins[1]), .AUX_PIN_ONE_O(o1), .AUX_PIN_ONE_OE(oe1),
        .AUX_PIN_TWO_I(pins[2]), .AUX_PIN_TWO_O(o2), .AUX_PIN_TWO_OE(oe2),
        .AUX_PIN_THREE_I(pins[3]), .AUX_PIN_THREE_O(o3),
        .AUX_PIN_THREE_OE(oe3),
        .ALERT_N_I(pins[0]), .ALERT_N_O(alo), .ALERT_N_OE(alert_oe),
        .ALERT_RESPONSE_EN(resp_en), .CONV_DONE(done)
    );

    // ======================================================
    // checking and access tasks
    task automatic close_out();
        begin
            $display("checks %0d errors %0d", n_tests, error_cnt);
            if (error_cnt == 0 && n_tests > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    task automatic chk(input string nm, input logic [15:0] s,
                       input logic [15:0] e);
        begin
            n_tests++;
            if (s !== e)
            begin
                error_cnt++;
                $display("ERROR %s expected %h seen %h", nm, e, s);
            end
        end
    endtask

    // write is taken at the second edge, strobe dropped there
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        begin
            @(posedge CLK);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge CLK);
            wr <= 1'b0;
        end
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        begin
            @(posedge CLK);
            addr <= a;
            rd <= 1'b1;
            @(posedge CLK);
            rd <= 1'b0;
            #1;
            chk("read data", {8'h00, rdata}, {8'h00, e});
        end
    endtask

    // one edge, then let its updates land
    task automatic step();
        begin
            @(posedge CLK);
            #1;
        end
    endtask

    // bounded wait for the conversion strobe; c counts the cycles
    task automatic wait_done(output logic [15:0] c);
        int i;
        begin
            c = 16'h0000;
            for (i = 0; i < 8000; i++)
            begin
                step();
                c = c + 16'h0001;
                if (done === 1'b1)
                    return;
            end
            error_cnt++;
            $display("ERROR conv_done expected 1 seen timeout");
            close_out();
        end
    endtask

    // ======================================================
    // main sequence
    initial
    begin
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        rd_reg(8'h05, 8'h00);
        wr_reg(8'h11, 8'h01);
        rd_reg(8'h11, 8'h01);
        wr_reg(8'h11, 8'h04);
        rd_reg(8'h11, 8'h04);
        wr_reg(8'h11, 8'h00);
        rd_reg(8'h1F, 8'hB0);
        wr_reg(8'h1F, 8'hFF);
        rd_reg(8'h1F, 8'hB0);
        // new pin levels need the two synchroniser stages first
        pins <= 4'h4;
        step();
        rd_reg(8'h1F, 8'h40);
        chk("crystal drive", {15'h0000, xdrv}, 16'h0000);
        chk("pin values", {12'h000, o1, o2, o3, alo}, 16'h0000);
        // pins: all three pulling, then all released
        wr_reg(8'h07, 8'hA0);
        step();
        chk("pin one oe", {15'h0000, oe1}, 16'h0001);
        chk("pin two oe", {15'h0000, oe2}, 16'h0001);
        chk("pin three oe", {15'h0000, oe3}, 16'h0001);
        wr_reg(8'h07, 8'h40);
        step();
        chk("pin one oe", {15'h0000, oe1}, 16'h0000);
        chk("pin two oe", {15'h0000, oe2}, 16'h0000);
        chk("pin three oe", {15'h0000, oe3}, 16'h0000);
        pg <= 1'b0;
        step();
        chk("pin one oe", {15'h0000, oe1}, 16'h0001);
        stress <= 1'b1;
        wr_reg(8'h07, 8'h52);
        step();
        chk("pin one oe", {15'h0000, oe1}, 16'h0000);
        chk("pin two oe", {15'h0000, oe2}, 16'h0001);
        wr_reg(8'h1C, 8'h40);
        step();
        chk("alert oe", {15'h0000, alert_oe}, 16'h0001);
        chk("response", {15'h0000, resp_en}, 16'h0000);
        wr_reg(8'h1C, 8'h80);
        step();
        chk("response", {15'h0000, resp_en}, 16'h0001);
        wr_reg(8'h1C, 8'h00);
        // first conversion in 12-bit mode, codes left justified
        wait_done(n);
        rd_reg(8'h30, 8'h20);
        rd_reg(8'h36, 8'h80);
        rd_reg(8'h38, 8'h80);
        rd_reg(8'h3A, 8'h80);
        rd_reg(8'h05, 8'hAA);
        rd_reg(8'h23, 8'h20);
        rd_reg(8'h29, 8'h01);
        // meter reset, then preset the counter
        wr_reg(8'h1D, 8'h40);
        wr_reg(8'h1D, 8'h00);
        rd_reg(8'h29, 8'h00);
        rd_reg(8'h23, 8'h00);
        wr_reg(8'h29, 8'h05);
        rd_reg(8'h29, 8'h05);
        wait_done(n);
        wait_done(n);
        chk("period 12", n, 16'h0C80);
        rd_reg(8'h29, 8'h07);
        wr_reg(8'h11, 8'h01);
        wait_done(n);
        wait_done(n);
        chk("period 16", n, 16'h1900);
        // external clock divided by 50, charge metering from a reset
        wr_reg(8'h1D, 8'h40);
        wr_reg(8'h1D, 8'h00);
        wr_reg(8'h10, 8'h99);
        ext_on <= 1'b1;
        wait_done(n);
        wait_done(n);
        chk("period ext", n, 16'h1900);
        rd_reg(8'h24, 8'h10);
        n = 16'h0000;
        repeat (8)
        begin
            step();
            n = n + {15'h0000, xdrv};
        end
        chk("crystal drive", n, 16'h0004);
        // counter one short of full, falling aux threshold one step up
        wr_reg(8'h26, 8'hFF);
        wr_reg(8'h27, 8'hFF);
        wr_reg(8'h28, 8'hFF);
        wr_reg(8'h29, 8'hFE);
        wr_reg(8'h0F, 8'h0F);
        wr_reg(8'h05, 8'h00);
        wr_reg(8'h1C, 8'h02);
        wait_done(n);
        chk("response", {15'h0000, resp_en}, 16'h0001);
        rd_reg(8'h05, 8'hEB);
        rd_reg(8'h29, 8'hFF);
        // alert per conversion, other inputs selected, counter wraps
        wr_reg(8'h1C, 8'h00);
        wr_reg(8'h07, 8'h44);
        wr_reg(8'h11, 8'h07);
        wait_done(n);
        chk("response", {15'h0000, resp_en}, 16'h0001);
        rd_reg(8'h3C, 8'h02);
        rd_reg(8'h43, 8'h01);
        rd_reg(8'h29, 8'h00);
        rd_reg(8'h1F, 8'h41);
        chk("alert oe", {15'h0000, alert_oe}, 16'h0001);
        close_out();
    end
endmodule
